// ### src/clre_pkg.sv
// shared constants, types and helpers for the current loop result encoder
`default_nettype none
package clre_pkg;
   localparam int unsigned CLRE_WORD_W = 16;
   localparam int unsigned CLRE_SET_WORDS = 10;
   localparam int unsigned CLRE_FIFO_DEPTH = 16;
   // word positions inside one result set
   localparam logic [3:0] IDX_LAST_WORD = 4'h9;
   localparam logic [3:0] IDX_RH = 4'h8;
   localparam logic [3:0] IDX_TEMP = 4'h9;
   localparam logic [15:0] NO_RESULT = 16'h8000;
   // loop currents in microamps
   localparam logic [15:0] UA_SYNC = 16'h0FA0;
   localparam logic [15:0] UA_IDLE = 16'h0FA0;
   localparam logic [15:0] UA_FIX_RH_BASE = 16'h0FA0;
   localparam logic [15:0] UA_FIX_CLASS_BASE = 16'h1388;
   localparam logic [15:0] UA_MUX_ZERO = 16'h1770;
   localparam logic [15:0] UA_CLASS_BASE = 16'h1B58;
   localparam logic [15:0] UA_TEMP_BASE = 16'h2710;
   localparam logic [15:0] UA_OVER = 16'h4E20;
   localparam logic [15:0] UA_NA = 16'h5DC0;
   localparam logic [15:0] UA_PER_MA = 16'h03E8;
   localparam logic [15:0] UA_HALF_MA = 16'h01F4;
   // code limits; class 00 is -1, table-2 code 000 is -2
   localparam logic signed [15:0] CLASS_MIN = -16'sh0001;
   localparam logic signed [15:0] CLASS_MAX = 16'sh000C;
   localparam logic signed [15:0] ISO_MAX = 16'sh001C;
   localparam logic signed [15:0] AS2_MIN = -16'sh0002;
   // slot counts
   localparam logic [3:0] N_CONTAM_CLASS = 4'h5;
   localparam logic [3:0] N_CONTAM_ISO = 4'h8;
   localparam logic [3:0] N_CONTAM_AS2 = 4'h7;
   localparam logic [3:0] N_MUX2_ISO = 4'h3;
   // reset values
   localparam logic [3:0] SLOT_RESET = 4'h0;
   localparam logic [15:0] UA_RESET = 16'h0FA0;

   typedef enum logic [1:0] {
      MODE_FIXED = 2'h0,
      MODE_MUX1 = 2'h1,
      MODE_MUX2 = 2'h2
   } clre_mode_type;

   typedef enum logic [2:0] {
      FMT_NAS = 3'h0,
      FMT_AS_T1 = 3'h1,
      FMT_ISO11218 = 3'h2,
      FMT_ISO4406 = 3'h3,
      FMT_AS_T2 = 3'h4
   } clre_fmt_type;

   typedef enum logic [3:0] {
      K_NA = 4'h0,
      K_SYNC = 4'h1,
      K_IDLE = 4'h2,
      K_FIX_CLASS = 4'h3,
      K_FIX_RH = 4'h4,
      K_CLASS = 4'h5,
      K_ISO = 4'h6,
      K_AS2 = 4'h7,
      K_RH = 4'h8,
      K_TEMP = 4'h9
   } clre_kind_type;

   // gray along fixed -> sync -> slot -> hold
   typedef enum logic [1:0] {
      ST_FIXED = 2'b00,
      ST_SYNC = 2'b01,
      ST_SLOT = 2'b11,
      ST_HOLD = 2'b10
   } clre_state_type;

   function automatic logic [15:0] clre_clamp(input int v);
      if (v < 0) begin
         return 16'h0000;
      end else if (v > int'(UA_NA)) begin
         return UA_NA;
      end
      return v[15:0];
   endfunction : clre_clamp

   function automatic logic [3:0] clre_n_contam(input clre_fmt_type f);
      case (f)
         FMT_ISO4406: return N_CONTAM_ISO;
         FMT_AS_T2: return N_CONTAM_AS2;
         default: return N_CONTAM_CLASS;
      endcase
   endfunction : clre_n_contam
endpackage : clre_pkg
`default_nettype wire

// ### src/clre_stream_if.sv
// valid/ready word stream between the block's own modules
`default_nettype none
interface clre_stream_if #(parameter int unsigned WIDTH = 16) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : clre_stream_if
`default_nettype wire

// ### src/clre_fifo.sv
// result word fifo with registered read data
`default_nettype none
module clre_fifo
   import clre_pkg::*;
#(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   clre_stream_if.snk in_s,
   clre_stream_if.src out_s
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wptr_q;
   logic [PW-1:0] rptr_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic ready_q;
   logic ovalid_q;
   logic [WIDTH-1:0] odata_q;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : next_ptr

   assign push = in_s.valid && ready_q;
   // refill the output register whenever it is empty or being taken
   assign pop = (cnt_q != '0) && (!ovalid_q || out_s.ready);
   assign in_s.ready = ready_q;
   assign out_s.valid = ovalid_q;
   assign out_s.data = odata_q;

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
         cnt_d = CW'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         ready_q <= 1'b0;
         wptr_q <= '0;
         rptr_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         ready_q <= (cnt_d < CNT_FULL);
         if (push) begin
            wptr_q <= next_ptr(wptr_q);
         end
         if (pop) begin
            rptr_q <= next_ptr(rptr_q);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wptr_q] <= in_s.data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ovalid_q <= 1'b0;
         odata_q <= '0;
      end else if (pop) begin
         ovalid_q <= 1'b1;
         odata_q <= mem_q[rptr_q];
      end else if (out_s.ready) begin
         ovalid_q <= 1'b0;
      end
   end
endmodule : clre_fifo
`default_nettype wire

// ### src/clre_encoder.sv
// maps one parameter value to a loop current in microamps
`default_nettype none
module clre_encoder
   import clre_pkg::*;
(
   input wire clre_kind_type kind,
   input wire logic [15:0] value,
   output logic [15:0] ua
);
   always_comb begin
      int v;
      v = int'($signed(value));
      ua = UA_NA;
      // missing value is out of range
      if (value == NO_RESULT && kind != K_SYNC && kind != K_IDLE) begin
         ua = UA_NA;
      end else begin
         case (kind)
            K_SYNC: ua = UA_SYNC;
            K_IDLE: ua = UA_IDLE;
            K_FIX_CLASS: begin
               if (v > int'(CLASS_MAX)) ua = UA_OVER;
               else if (v < int'(CLASS_MIN)) ua = UA_NA;
               else ua = clre_clamp(int'(UA_FIX_CLASS_BASE) + v * int'(UA_PER_MA));
            end
            K_FIX_RH: ua = clre_clamp(int'(UA_FIX_RH_BASE) + (v * 8) / 5);
            K_CLASS: begin
               if (v > int'(CLASS_MAX)) ua = UA_OVER;
               else if (v < int'(CLASS_MIN)) ua = UA_NA;
               else ua = clre_clamp(int'(UA_CLASS_BASE) + v * int'(UA_PER_MA));
            end
            K_ISO: begin
               if (v > int'(ISO_MAX)) ua = UA_OVER;
               else if (v < 0) ua = UA_NA;
               else ua = clre_clamp(int'(UA_MUX_ZERO) + v * int'(UA_HALF_MA));
            end
            // six plus half of code plus two
            K_AS2: begin
               if (v > int'(CLASS_MAX)) ua = UA_OVER;
               else if (v < int'(AS2_MIN)) ua = UA_NA;
               else ua = clre_clamp(int'(UA_MUX_ZERO) + (v + 2) * int'(UA_HALF_MA));
            end
            // humidity scaled by 100 lands on microamps
            K_RH: ua = clre_clamp(int'(UA_MUX_ZERO) + v);
            K_TEMP: ua = clre_clamp(int'(UA_TEMP_BASE) + v);
            default: ua = UA_NA;
         endcase
      end
   end
endmodule : clre_encoder
`default_nettype wire

// ### src/clre_top.sv
// current loop result encoder: result intake, frame sequencer, loop drive
`default_nettype none
module clre_top
   import clre_pkg::*;
#(
   parameter int unsigned WORD_W = CLRE_WORD_W,
   parameter int unsigned FIFO_DEPTH = CLRE_FIFO_DEPTH
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [WORD_W-1:0] RESULT_DATA,
   input wire logic RESULT_VALID,
   output logic RESULT_READY,
   input wire logic ONE_SEC_TICK,
   input wire logic [1:0] CFG_MODE,
   input wire logic [2:0] CFG_FORMAT,
   output logic [15:0] LOOP_A_UA,
   output logic [15:0] LOOP_B_UA,
   output logic FRAME_SYNC
);
   clre_stream_if #(.WIDTH(WORD_W)) in_s ();
   clre_stream_if #(.WIDTH(WORD_W)) out_s ();

   logic [WORD_W-1:0] pend_q [CLRE_SET_WORDS];
   logic [WORD_W-1:0] snap_q [CLRE_SET_WORDS];
   logic [3:0] widx_q;
   logic pend_full_q;
   logic load;
   clre_mode_type mode_q;
   clre_fmt_type fmt_q;
   clre_mode_type mode_in;
   clre_fmt_type fmt_in;
   clre_state_type state_q;
   logic [3:0] slot_q;
   logic restart;
   logic frame_start;
   logic capture;
   logic [3:0] n_contam;
   logic [3:0] last_mux1;
   logic [3:0] last_mux2;
   logic [3:0] sel_idx;
   clre_kind_type kind_a;
   clre_kind_type kind_b;
   clre_kind_type contam_kind;
   logic [15:0] ua_a;
   logic [15:0] ua_b;
   logic [15:0] val_a;
   logic frame_start_sync_seen;

   ////////////////////////////////////////////////////////////////////////
   // intake: fifo, then assembly of a ten-word result set
   assign in_s.valid = RESULT_VALID;
   assign in_s.data = RESULT_DATA;
   assign RESULT_READY = in_s.ready;

   clre_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(SYS_CLK),
      .rst(RST),
      .in_s(in_s.snk),
      .out_s(out_s.src)
   );

   // a finished set waits for its frame, so the fifo backs up meanwhile
   assign out_s.ready = !pend_full_q;
   assign load = out_s.valid && !pend_full_q;

   always_ff @(posedge SYS_CLK) begin
      if (load) begin
         pend_q[widx_q] <= out_s.data;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         widx_q <= SLOT_RESET;
         pend_full_q <= 1'b0;
      end else begin
         if (load) begin
            widx_q <= (widx_q == IDX_LAST_WORD) ? SLOT_RESET : 4'(widx_q + 1'b1);
         end
         if (load && widx_q == IDX_LAST_WORD) begin
            pend_full_q <= 1'b1;
         end else if (capture) begin
            pend_full_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frame sequencer
   assign mode_in = clre_mode_type'(CFG_MODE);
   assign fmt_in = clre_fmt_type'(CFG_FORMAT);
   assign restart = (mode_in != mode_q) || (fmt_in != fmt_q);
   assign n_contam = clre_n_contam(fmt_q);
   assign last_mux1 = 4'(n_contam + 4'h2);
   assign last_mux2 = (fmt_q == FMT_ISO4406) ? 4'(N_MUX2_ISO - 1'b1) : SLOT_RESET;

   always_comb begin
      frame_start = 1'b0;
      if (restart) begin
         frame_start = (mode_in != MODE_FIXED);
      end else if (ONE_SEC_TICK) begin
         if (mode_q == MODE_MUX1 && state_q == ST_SLOT && slot_q == last_mux1) begin
            frame_start = 1'b1;
         end else if (mode_q == MODE_MUX2 && state_q == ST_HOLD) begin
            frame_start = 1'b1;
         end
      end
   end

   // capture only at frame start; fixed mode follows each new set
   assign capture = pend_full_q && (frame_start || (mode_q == MODE_FIXED && !restart));

   // power-up snapshot reads as no result, never as an unknown current
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         snap_q <= '{default: WORD_W'(NO_RESULT)};
      end else if (capture) begin
         snap_q <= pend_q;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         mode_q <= MODE_FIXED;
         fmt_q <= FMT_NAS;
         state_q <= ST_FIXED;
         slot_q <= SLOT_RESET;
      end else if (restart) begin
         mode_q <= mode_in;
         fmt_q <= fmt_in;
         slot_q <= SLOT_RESET;
         case (mode_in)
            MODE_MUX1: state_q <= ST_SYNC;
            MODE_MUX2: state_q <= ST_SLOT;
            default: state_q <= ST_FIXED;
         endcase
      end else if (ONE_SEC_TICK) begin
         case (state_q)
            ST_SYNC: begin
               state_q <= ST_SLOT;
               slot_q <= 4'h1;
            end
            ST_SLOT: begin
               if (mode_q == MODE_MUX1) begin
                  // back to the marker after temperature
                  if (slot_q == last_mux1) begin
                     state_q <= ST_SYNC;
                     slot_q <= SLOT_RESET;
                  end else begin
                     slot_q <= 4'(slot_q + 1'b1);
                  end
               end else if (slot_q == last_mux2) begin
                  // final parameter gets a second tick
                  state_q <= ST_HOLD;
               end else begin
                  slot_q <= 4'(slot_q + 1'b1);
               end
            end
            ST_HOLD: begin
               state_q <= ST_SLOT;
               slot_q <= SLOT_RESET;
            end
            default: state_q <= ST_FIXED;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slot to parameter mapping
   always_comb begin
      case (fmt_q)
         FMT_ISO4406: contam_kind = K_ISO;
         FMT_AS_T2: contam_kind = K_AS2;
         default: contam_kind = K_CLASS;
      endcase
   end

   always_comb begin
      sel_idx = SLOT_RESET;
      kind_a = K_NA;
      kind_b = K_IDLE;
      case (mode_q)
         MODE_FIXED: begin
            // other formats get no fixed output
            kind_a = (fmt_q == FMT_NAS) ? K_FIX_CLASS : K_NA;
            kind_b = (fmt_q == FMT_NAS) ? K_FIX_RH : K_NA;
            sel_idx = (fmt_q == FMT_NAS) ? SLOT_RESET : IDX_RH;
         end
         MODE_MUX1: begin
            // B idles while A carries the frame
            kind_b = K_IDLE;
            if (state_q == ST_SYNC) begin
               kind_a = K_SYNC;
            end else if (slot_q == 4'(n_contam + 4'h1)) begin
               kind_a = K_RH;
               sel_idx = IDX_RH;
            end else if (slot_q == last_mux1) begin
               kind_a = K_TEMP;
               sel_idx = IDX_TEMP;
            end else begin
               kind_a = contam_kind;
               sel_idx = 4'(slot_q - 1'b1);
            end
         end
         MODE_MUX2: begin
            // overall code, or three cumulative codes
            kind_a = contam_kind;
            sel_idx = slot_q;
            kind_b = K_RH;
         end
         default: begin
            kind_a = K_NA;
            kind_b = K_NA;
         end
      endcase
   end

   assign val_a = snap_q[sel_idx];

   clre_encoder u_enc_a (
      .kind(kind_a),
      .value(val_a),
      .ua(ua_a)
   );

   clre_encoder u_enc_b (
      .kind(kind_b),
      .value(snap_q[IDX_RH]),
      .ua(ua_b)
   );

   ////////////////////////////////////////////////////////////////////////
   // registered loop drive
   // both loops driven every cycle
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         LOOP_A_UA <= UA_RESET;
         LOOP_B_UA <= UA_RESET;
         FRAME_SYNC <= 1'b0;
      end else begin
         LOOP_A_UA <= ua_a;
         LOOP_B_UA <= ua_b;
         FRAME_SYNC <= (kind_a == K_SYNC);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_sync_level;
      @(posedge SYS_CLK) disable iff (RST)
      (state_q == ST_SYNC) |=> (LOOP_A_UA == UA_SYNC) && FRAME_SYNC;
   endproperty
   a_sync_level: assert property (p_sync_level) else $error("sync level wrong");

   property p_no_result;
      @(posedge SYS_CLK) disable iff (RST)
      (mode_q == MODE_MUX1 && state_q == ST_SLOT && val_a == NO_RESULT)
         |=> (LOOP_A_UA == UA_NA);
   endproperty
   a_no_result: assert property (p_no_result) else $error("missing value not 24 mA");

   property p_fixed_other_fmt;
      @(posedge SYS_CLK) disable iff (RST)
      (mode_q == MODE_FIXED && fmt_q != FMT_NAS)
         |=> (LOOP_A_UA == UA_NA) && (LOOP_B_UA == UA_NA);
   endproperty
   a_fixed_other_fmt: assert property (p_fixed_other_fmt) else $error("fixed mode misused");

   property p_slot_on_tick;
      @(posedge SYS_CLK) disable iff (RST)
      (!ONE_SEC_TICK && !restart) |=> $stable(slot_q) && $stable(state_q);
   endproperty
   a_slot_on_tick: assert property (p_slot_on_tick) else $error("slot moved without tick");

   property p_wrap_to_sync;
      @(posedge SYS_CLK) disable iff (RST)
      (mode_q == MODE_MUX1 && state_q == ST_SLOT && slot_q == last_mux1 && ONE_SEC_TICK
         && !restart) |=> (state_q == ST_SYNC) ##1 (LOOP_A_UA == UA_SYNC);
   endproperty
   a_wrap_to_sync: assert property (p_wrap_to_sync) else $error("frame did not restart");

   property p_mux2_no_sync;
      @(posedge SYS_CLK) disable iff (RST)
      (mode_q == MODE_MUX2) |-> (state_q != ST_SYNC) && !frame_start_sync_seen;
   endproperty
   assign frame_start_sync_seen = (kind_a == K_SYNC) || (kind_b == K_TEMP);
   a_mux2_no_sync: assert property (p_mux2_no_sync) else $error("scheme 2 sent a marker");

   property p_snap_held;
      @(posedge SYS_CLK) disable iff (RST)
      (!capture) |=> $stable(snap_q[0]) && $stable(snap_q[IDX_TEMP]);
   endproperty
   a_snap_held: assert property (p_snap_held) else $error("set changed mid frame");

   property p_fixed_class12;
      @(posedge SYS_CLK) disable iff (RST)
      (mode_q == MODE_FIXED && fmt_q == FMT_NAS && val_a == 16'h000C)
         |=> (LOOP_A_UA == 16'h4268);
   endproperty
   a_fixed_class12: assert property (p_fixed_class12) else $error("class 12 not 17 mA");

   property p_range;
      @(posedge SYS_CLK) disable iff (RST)
      (mode_q != MODE_MUX1 || state_q != ST_SLOT || kind_a != K_TEMP)
         |=> (LOOP_A_UA <= UA_NA) && (LOOP_B_UA <= UA_NA) && (LOOP_B_UA >= UA_FIX_RH_BASE
         || LOOP_B_UA == 16'h0000);
   endproperty
   a_range: assert property (p_range) else $error("loop current out of span");
endmodule : clre_top
`default_nettype wire

// ### verif/clre_loop_reader.sv
// controller model: samples loop A once a second, framed by the marker
`default_nettype none
module clre_loop_reader (
   input wire logic sys_clk,
   input wire logic one_sec_tick,
   input wire logic frame_sync,
   input wire logic [15:0] loop_a_ua
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] slots [16];
   int n = 0;
   int run = 0;
   int sync_len = 0;
   // marker restarts timing
   // sampled at the tick edge, so each slot is read at its very end
   always @(posedge sys_clk) begin
      if (one_sec_tick && frame_sync) begin
         run <= run + 1;
         n <= 0;
      end else if (one_sec_tick) begin
         if (run != 0) begin
            sync_len <= run;
         end
         run <= 0;
         slots[n[3:0]] <= loop_a_ua;
         n <= n + 1;
      end
   end
endmodule : clre_loop_reader
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the current loop result encoder
`default_nettype none
module tb_top
   import clre_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] res_data = 16'h0000;
   logic res_valid = 1'b0;
   logic tick = 1'b0;
   logic [1:0] cfg_mode = 2'h0;
   logic [2:0] cfg_fmt = 3'h0;
   logic res_ready;
   logic frame_sync;
   logic [15:0] loop_a;
   logic [15:0] loop_b;
   logic saw_full = 1'b0;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int tick_cnt = 0;

   clre_top i_dut (.SYS_CLK(sys_clk), .RST(rst), .RESULT_DATA(res_data),
      .RESULT_VALID(res_valid), .RESULT_READY(res_ready), .ONE_SEC_TICK(tick),
      .CFG_MODE(cfg_mode), .CFG_FORMAT(cfg_fmt), .LOOP_A_UA(loop_a), .LOOP_B_UA(loop_b),
      .FRAME_SYNC(frame_sync));
   clre_loop_reader i_plc (.sys_clk(sys_clk), .one_sec_tick(tick), .frame_sync(frame_sync),
      .loop_a_ua(loop_a));

   always #4 sys_clk = ~sys_clk;

   // a second shrunk to 16 cycles; the run stays near 1550 cycles
   always @(negedge sys_clk) begin
      tick_cnt <= (tick_cnt == 15) ? 0 : tick_cnt + 1;
      tick <= (tick_cnt == 15);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check16

   // valid held across words; only dropped after the last acceptance
   // ready is read at the falling edge, where it is settled for the next rising one
   task automatic load(input logic [15:0] w [10], input int copies);
      int t;
      logic acc;
      res_valid = 1'b1;
      for (int c = 0; c < copies; c++) begin
         for (int k = 0; k < 10; k++) begin
            res_data = w[k];
            t = 0;
            do begin
               acc = (res_ready === 1'b1);
               if (!acc) begin
                  saw_full = 1'b1;
               end
               @(negedge sys_clk);
               t++;
            end while (!acc && t < 2000);
         end
      end
      res_valid = 1'b0;
   endtask : load

   task automatic wait_sync(input logic lvl);
      int t;
      t = 0;
      while (frame_sync !== lvl && t < 1000) begin
         @(negedge sys_clk);
         t++;
      end
   endtask : wait_sync

   task automatic run_frame(input logic [2:0] fmt, input logic [15:0] w [10], input int copies,
      input logic [15:0] e [10], input int n);
      cfg_mode = MODE_MUX1;
      cfg_fmt = fmt;
      load(w, copies);
      for (int k = 0; k < 2; k++) begin
         wait_sync(1'b0);
         wait_sync(1'b1);
      end
      check16("slot count", 16'(n), 16'(i_plc.n));
      check16("marker ticks", 16'h0001, 16'(i_plc.sync_len));
      for (int k = 0; k < n; k++) begin
         check16("slot", e[k], i_plc.slots[k]);
      end
      check16("loop b idle", 16'h0FA0, loop_b);
   endtask : run_frame

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (5) @(negedge sys_clk);
      check16("reset a", 16'h0FA0, loop_a);
      check16("reset b", 16'h0FA0, loop_b);
      check16("reset ready", 16'h0000, {15'h0000, res_ready});
      check16("reset sync", 16'h0000, {15'h0000, frame_sync});
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      check16("power-up a", 16'h5DC0, loop_a);
      $display("test reset done");
   endtask : t_reset

   task automatic t_fixed();
      load('{16'h000C, 0, 0, 0, 0, 0, 0, 0, 16'h1388, 0}, 1);
      repeat (10) @(negedge sys_clk);
      check16("fixed a", 16'h4268, loop_a);
      check16("fixed b", 16'h2EE0, loop_b);
      cfg_fmt = FMT_AS_T1;
      repeat (4) @(negedge sys_clk);
      check16("fixed bad fmt", 16'h5DC0, loop_a);
      check16("fixed bad fmt b", 16'h5DC0, loop_b);
      $display("test fixed done");
   endtask : t_fixed

   task automatic t_nas();
      run_frame(FMT_NAS, '{16'hFFFF, 0, 16'h000C, 16'h000D, 16'h8000, 0, 0, 0, 16'h2710,
         16'hFE0C}, 1, '{16'h1770, 16'h1B58, 16'h4A38, 16'h4E20, 16'h5DC0, 16'h3E80,
         16'h251C, 0, 0, 0}, 7);
      $display("test class frame done");
   endtask : t_nas

   task automatic t_iso();
      run_frame(FMT_ISO4406, '{0, 16'h001C, 16'h001D, 16'hFFFF, 16'h0002, 16'h0004, 16'h0006,
         16'h8000, 16'h8000, 16'h03E8}, 1, '{16'h1770, 16'h4E20, 16'h4E20, 16'h5DC0,
         16'h1B58, 16'h1F40, 16'h2328, 16'h5DC0, 16'h5DC0, 16'h2AF8}, 10);
      $display("test cumulative frame done");
   endtask : t_iso

   task automatic t_as2();
      // four sets back to back fill the fifo while sets wait for frames
      run_frame(FMT_AS_T2, '{16'hFFFE, 16'hFFFF, 0, 16'h000C, 16'h000D, 16'h0001, 16'h0002,
         0, 0, 0}, 4, '{16'h1770, 16'h1964, 16'h1B58, 16'h32C8, 16'h4E20, 16'h1D4C,
         16'h1F40, 16'h1770, 16'h2710, 0}, 9);
      check16("fifo refused", 16'h0001, {15'h0000, saw_full});
      $display("test table-two frame done");
   endtask : t_as2

   task automatic t_mux2();
      logic [15:0] s [9];
      int i;
      cfg_mode = MODE_MUX2;
      cfg_fmt = FMT_ISO4406;
      load('{16'h0004, 16'h000A, 16'h0014, 0, 0, 0, 0, 0, 16'h09C4, 0}, 1);
      repeat (6) @(posedge sys_clk iff tick === 1'b1);
      for (int k = 0; k < 9; k++) begin
         @(posedge sys_clk iff tick === 1'b1);
         s[k] = loop_a;
         check16("no marker", 16'h0000, {15'h0000, frame_sync});
      end
      i = (s[1] === 16'h1F40) ? 1 : (s[2] === 16'h1F40) ? 2 : (s[3] === 16'h1F40) ? 3 : 0;
      check16("code 0", 16'h1F40, s[i]);
      check16("code 1", 16'h2AF8, s[i + 1]);
      check16("code 2", 16'h3E80, s[i + 2]);
      check16("code 2 held", 16'h3E80, s[i + 3]);
      check16("wrap", 16'h1F40, s[i + 4]);
      check16("static b", 16'h2134, loop_b);
      // class format in scheme 2 shows only word 0 of the held set
      cfg_fmt = FMT_NAS;
      repeat (40) @(negedge sys_clk);
      check16("overall code", 16'h2AF8, loop_a);
      cfg_mode = 2'h3;
      repeat (3) @(negedge sys_clk);
      check16("mode 3 a", 16'h5DC0, loop_a);
      check16("mode 3 b", 16'h5DC0, loop_b);
      $display("test scheme two done");
   endtask : t_mux2

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   initial begin
      t_reset();
      t_fixed();
      t_nas();
      t_iso();
      t_as2();
      t_mux2();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
